// ===== verilog/can_msgbuf_length_control.v
// length code and frame control registers of the 32 message buffers
`timescale 1ns/10ps
`include "can_msgbuf_defines.vh"

// How it works
// [R1] 4-bit length code; codes above eight mean eight
// [R2] receive writes frame byte count to length
// [R3] registers reached only as single byte accesses
// [R4] extended remote frame stored: length becomes zero
// [R5] software writes zero to reserved bits
// [R6] control bits: flag, answer, stamp, irq, overwrite, frame
// [R7] remote frame with flag enable sets done
// [R8] flag enable set: auto-answer bit ignored
// [R9] flag enable clear: no notify for remote
// [R10] auto-answer bit enables automatic remote answering
// [R11] auto-answer only for transmit buffers
// [R12] remote frame type forces auto-answer off
// [R13] stamp insert applies to transmit buffers
// [R14] stamp replaces last two bytes when length two+
// [R15] bus r1/r0 copied into control bits 2/1
// [R16] per-buffer interrupt enable gates requests
// [R17] overwrite bit marks store onto done buffer
// [R18] frame type bit selects remote frame sending
// [R19] interrupt on send, receive, or flagged remote
// [R20] buffers 0x20 apart, control one above length
module can_msgbuf_length_control (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave, 8-bit data
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [9:0]  adr_i,
   input  wire        sel_i,
   input  wire [7:0]  dat_i,
   output reg  [7:0]  dat_o,
   output reg         ack_o,
   // receive store from the protocol engine
   input  wire        rx_store_i,
   input  wire [4:0]  rx_buf_i,
   input  wire [3:0]  rx_dlc_i,
   input  wire        rx_ide_i,
   input  wire        rx_rtr_i,
   input  wire        rx_r1_i,
   input  wire        rx_r0_i,
   // done flags and buffer direction from the status block
   input  wire [31:0] done_flags_i,
   input  wire [31:0] buf_is_tx_i,
   // remote frame matched to a buffer
   input  wire        rmt_rx_i,
   input  wire [4:0]  rmt_buf_i,
   // transmit side
   input  wire        tx_sent_i,
   input  wire [4:0]  tx_buf_i,
   input  wire [2:0]  tx_byte_idx_i,
   input  wire [7:0]  tx_data_i,
   input  wire        tx_sof_i,
   input  wire [15:0] tstamp_i,
   output reg  [3:0]  tx_len_o,
   output reg         tx_remote_o,
   output reg         tx_stamp_o,
   output reg  [7:0]  tx_byte_o,
   // events towards status and interrupt logic
   output reg         done_set_o,
   output reg         answer_req_o,
   output reg  [4:0]  event_buf_o,
   output reg         irq_req_o,
   output reg  [1:0]  irq_kind_o,
   output reg  [4:0]  irq_buf_o
);

// ****************************************************************
// bus decode
// ****************************************************************
wire [4:0] bus_buf;
wire [4:0] bus_off;
wire       bus_req;
wire       bus_wr;
wire       hit_len;
wire       hit_ctl;

assign bus_buf = adr_i[9:5];
assign bus_off = adr_i[4:0];
// one new request per handshake; the ack cycle itself is not a new request
assign bus_req = cyc_i & stb_i & ~ack_o;
// byte lane must be active, every access is one byte wide
// sel_i low is still acked, but nothing is written
assign bus_wr  = bus_req & we_i & sel_i;                     // see [R3]
assign hit_len = (bus_off == `MB_LEN_OFF);                    // see [R20]
assign hit_ctl = (bus_off == `MB_CTL_OFF);                    // see [R20]

// ****************************************************************
// per-buffer storage
// ****************************************************************
wire [127:0] len_all;
wire [255:0] ctl_all;
wire [3:0]   rx_len;

// extended-id remote frames always land with a zero length
assign rx_len = (rx_ide_i & rx_rtr_i) ? `LEN_RESET : rx_dlc_i;   // see [R4] see [R2]

genvar g;
generate
   for (g = 0; g < `MB_COUNT; g = g + 1) begin : entry
      reg  [3:0] len;
      reg  [7:0] ctl;
      wire       sel_me;
      wire       rx_me;

      // compare at full width, the loop index is a 32-bit integer
      assign sel_me = ({27'h0, bus_buf} == g);
      assign rx_me  = rx_store_i & ({27'h0, rx_buf_i} == g);
      assign len_all[g*4 +: 4] = len;
      assign ctl_all[g*8 +: 8] = ctl;

      always @(posedge clk_i) begin
         if (rst_i) begin
            len <= `LEN_RESET;
            ctl <= `CTL_RESET;
         end else begin
            // upper length bits are reserved and not kept
            if (bus_wr & sel_me & hit_len) begin
               len <= dat_i[3:0];                            // see [R5]
            end
            // reserved control bits 2:1 stay writable; a store overwrites them
            if (bus_wr & sel_me & hit_ctl) begin
               ctl <= dat_i;                                 // see [R6]
            end
            // placed last so a store wins over a same-cycle write
            if (rx_me) begin
               len <= rx_len;                                // see [R2]
               ctl[`CTL_BUS_R1]    <= rx_r1_i;               // see [R15]
               ctl[`CTL_BUS_R0]    <= rx_r0_i;               // see [R15]
               ctl[`CTL_OVERWRITE] <= done_flags_i[g];       // see [R17]
            end
         end
      end
   end
endgenerate

// ****************************************************************
// register read and acknowledge
// ****************************************************************
reg [7:0] next_dat;

always @* begin
   next_dat = 8'h00;
   case (bus_off)
      `MB_LEN_OFF: begin
         next_dat = {4'h0, len_all[{bus_buf, 2'b00} +: 4]};
      end
      `MB_CTL_OFF: begin
         next_dat = ctl_all[{bus_buf, 3'b000} +: 8];
      end
      default: begin
         // unmapped offsets read as zero
         next_dat = 8'h00;
      end
   endcase
end

always @(posedge clk_i) begin
   if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 8'h00;
   end else begin
      // unmapped offsets still answer, reading zero
      ack_o <= bus_req;
      if (bus_req & ~we_i) begin
         dat_o <= next_dat;
      end
   end
end

// ****************************************************************
// remote frame reaching a buffer
// ****************************************************************
wire [7:0] rmt_ctl;
wire       rmt_tx;
wire       rmt_flag;
wire       rmt_answer;

assign rmt_ctl  = ctl_all[{rmt_buf_i, 3'b000} +: 8];
assign rmt_tx   = buf_is_tx_i[rmt_buf_i];
assign rmt_flag = rmt_rx_i & rmt_tx & rmt_ctl[`CTL_REMOTE_FLAG];          // see [R7]
// answer bit matters only on transmit buffers, without flag enable,
// and never for a buffer that itself sends remote frames
assign rmt_answer = rmt_rx_i & rmt_tx                                       // see [R11]
                  & ~rmt_ctl[`CTL_REMOTE_FLAG]                              // see [R8]
                  & ~rmt_ctl[`CTL_FRAME_TYPE]                               // see [R12]
                  & rmt_ctl[`CTL_AUTO_ANSWER];                              // see [R10]

// status and answer logic act on these pulses; this block only decides
always @(posedge clk_i) begin
   if (rst_i) begin
      done_set_o   <= 1'b0;
      answer_req_o <= 1'b0;
      event_buf_o  <= 5'h00;
   end else begin
      // flag enable clear without answer: no done or answer pulse, only event_buf_o is loaded
      done_set_o   <= rmt_flag;                              // see [R7] see [R9]
      answer_req_o <= rmt_answer;                            // see [R10]
      if (rmt_rx_i) begin
         event_buf_o <= rmt_buf_i;
      end
   end
end

// ****************************************************************
// interrupt requests
// ****************************************************************
wire [7:0] rx_ctl;
wire [7:0] sent_ctl;
wire       rx_ie;
wire       tx_ie;
wire       rmt_ie;
reg  [1:0] next_irq_kind;
reg  [4:0] next_irq_buf;

assign rx_ctl   = ctl_all[{rx_buf_i, 3'b000} +: 8];
assign sent_ctl = ctl_all[{tx_buf_i, 3'b000} +: 8];
assign rx_ie    = rx_store_i & rx_ctl[`CTL_IRQ_ENABLE];                     // see [R16]
assign tx_ie    = tx_sent_i & sent_ctl[`CTL_IRQ_ENABLE];                    // see [R16]
assign rmt_ie   = rmt_flag & rmt_ctl[`CTL_IRQ_ENABLE];                      // see [R16]

// one request per cycle; receive first, then send, then remote.
// a losing event gets no request of its own, so software must poll
// status when several buffers finish in the same cycle
always @* begin
   next_irq_kind = irq_kind_o;
   next_irq_buf  = irq_buf_o;
   if (rx_ie) begin
      next_irq_kind = `EVT_RX_STORED;
      next_irq_buf  = rx_buf_i;
   end else if (tx_ie) begin
      next_irq_kind = `EVT_TX_SENT;
      next_irq_buf  = tx_buf_i;
   end else if (rmt_ie) begin
      next_irq_kind = `EVT_REMOTE_DONE;
      next_irq_buf  = rmt_buf_i;
   end
end

always @(posedge clk_i) begin
   if (rst_i) begin
      irq_req_o  <= 1'b0;
      irq_kind_o <= `EVT_RX_STORED;
      irq_buf_o  <= 5'h00;
   end else begin
      irq_req_o  <= rx_ie | tx_ie | rmt_ie;                  // see [R19]
      irq_kind_o <= next_irq_kind;
      irq_buf_o  <= next_irq_buf;
   end
end

// ****************************************************************
// transmit view of the selected buffer
// ****************************************************************
reg  [15:0] stamp_q;
wire [3:0]  tx_code;
wire [7:0]  tx_ctl;
wire [3:0]  tx_bytes;
wire        tx_ins;
reg  [7:0]  next_byte;

assign tx_code  = len_all[{tx_buf_i, 2'b00} +: 4];
assign tx_ctl   = ctl_all[{tx_buf_i, 3'b000} +: 8];
assign tx_bytes = (tx_code > `LEN_MAX_BYTES) ? `LEN_MAX_BYTES : tx_code;  // see [R1]
assign tx_ins   = tx_ctl[`CTL_STAMP_INSERT] & buf_is_tx_i[tx_buf_i]        // see [R13]
                & (tx_bytes >= `LEN_STAMP_MIN);

// tx outputs follow the selected buffer one cycle late; the frame
// engine must hold tx_buf_i steady for the whole frame
// stored bytes in the last two slots are dropped, high stamp byte first
always @* begin
   next_byte = tx_data_i;
   if (tx_ins & ({1'b0, tx_byte_idx_i} == tx_bytes - 4'h2)) begin
      next_byte = stamp_q[15:8];                              // see [R14]
   end else if (tx_ins & ({1'b0, tx_byte_idx_i} == tx_bytes - 4'h1)) begin
      next_byte = stamp_q[7:0];                               // see [R14]
   end
end

always @(posedge clk_i) begin
   if (rst_i) begin
      stamp_q     <= 16'h0000;
      tx_len_o    <= `LEN_RESET;
      tx_remote_o <= 1'b0;
      tx_stamp_o  <= 1'b0;
      tx_byte_o   <= 8'h00;
   end else begin
      // counter value frozen at start of frame
      if (tx_sof_i) begin
         stamp_q <= tstamp_i;                                 // see [R14]
      end
      tx_len_o    <= tx_bytes;                                // see [R1]
      tx_remote_o <= tx_ctl[`CTL_FRAME_TYPE];                 // see [R18]
      tx_stamp_o  <= tx_ins;                                  // see [R13]
      tx_byte_o   <= next_byte;
   end
end

endmodule

// ===== verilog/can_msgbuf_defines.vh
// constants for the message buffer length and control block
`ifndef CAN_MSGBUF_DEFINES_VH
`define CAN_MSGBUF_DEFINES_VH

// ****************************************************************
// geometry
// ****************************************************************
`define MB_COUNT          32
`define MB_IDX_W          5
`define MB_ADR_W          10
`define MB_STRIDE         8'h20
`define MB_LEN_OFF        5'h04
`define MB_CTL_OFF        5'h05

// ****************************************************************
// length register
// ****************************************************************
`define LEN_CODE_W        4
`define LEN_MAX_BYTES     4'h8
`define LEN_RESET         4'h0
`define LEN_STAMP_MIN     4'h2

// ****************************************************************
// control register fields
// ****************************************************************
`define CTL_REMOTE_FLAG   7
`define CTL_AUTO_ANSWER   6
`define CTL_STAMP_INSERT  5
`define CTL_IRQ_ENABLE    4
`define CTL_OVERWRITE     3
`define CTL_BUS_R1        2
`define CTL_BUS_R0        1
`define CTL_FRAME_TYPE    0
`define CTL_RESET         8'h00

// ****************************************************************
// event codes on the interrupt request port
// ****************************************************************
`define EVT_RX_STORED     2'h0
`define EVT_TX_SENT       2'h1
`define EVT_REMOTE_DONE   2'h2

`endif

// ===== testbench/can_msgbuf_checker.sv
// port assertions for the message buffer block
`timescale 1ns/10ps
module can_msgbuf_checker(
   input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, rx_store_i, tx_sent_i,
   input wire logic        rmt_rx_i, tx_stamp_o, done_set_o, answer_req_o, irq_req_o,
   input wire logic [4:0]  rmt_buf_i, tx_buf_i,
   input wire logic [31:0] buf_is_tx_i,
   input wire logic [3:0]  tx_len_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_done_cause: assert property (done_set_o |->
      $past(rmt_rx_i && buf_is_tx_i[rmt_buf_i]))
      else $error("done set without remote frame");
   a_rx_quiet: assert property (rmt_rx_i && !buf_is_tx_i[rmt_buf_i] |=> !answer_req_o)
      else $error("answer for receive buffer");
   a_flag_excl: assert property (done_set_o |-> !answer_req_o)
      else $error("answer while flag enabled");
   a_len_cap: assert property (tx_len_o <= 4'h8)
      else $error("length above eight");
   a_stamp_tx: assert property (tx_stamp_o |-> $past(buf_is_tx_i[tx_buf_i]))
      else $error("stamp on receive buffer");
   a_irq_cause: assert property (irq_req_o |-> $past(rx_store_i) || $past(tx_sent_i)
      || $past(rmt_rx_i))
      else $error("irq without event");
endmodule

// ===== testbench/can_peer_model.sv
// far-side node: delivers received and remote frames
`timescale 1ns/10ps
module can_peer_model(
   input wire logic        clk_i, go_i, rgo_i,
   input wire logic [12:0] frm_i,
   output logic            rx_store_o, rmt_rx_o, ide_o, rtr_o, r1_o, r0_o,
   output logic [4:0]      buf_o,
   output logic [3:0]      dlc_o);
   initial {rx_store_o, rmt_rx_o, buf_o, dlc_o, ide_o, rtr_o, r1_o, r0_o} = '0;
   always @(posedge clk_i) begin
      rx_store_o <= go_i;
      rmt_rx_o   <= rgo_i;
      // fields only mean something with a pulse; otherwise they toggle
      if (go_i || rgo_i)
         {buf_o, dlc_o, ide_o, rtr_o, r1_o, r0_o} <= frm_i;
      else
         {buf_o, dlc_o, ide_o, rtr_o, r1_o, r0_o} <= ~{buf_o, dlc_o, ide_o, rtr_o, r1_o, r0_o};
   end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the message buffer block
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sel_i = 0, go = 0, rgo = 0;
   logic sl = 1;
   logic tx_sent_i = 0, tx_sof_i = 0, rx_store_i, rx_ide_i, rx_rtr_i, rx_r1_i, rx_r0_i;
   logic rmt_rx_i, ack_o, tx_remote_o, tx_stamp_o, done_set_o, answer_req_o, irq_req_o;
   logic [9:0] adr_i = 0;
   logic [7:0] dat_i = 0, tx_data_i = 0, dat_o, tx_byte_o, q, o, c;
   logic [12:0] frm = 0;
   logic [31:0] done_flags_i = 0, buf_is_tx_i = 0;
   logic [4:0] tx_buf_i = 0, rx_buf_i, rmt_buf_i, event_buf_o, irq_buf_o, b;
   logic [3:0] rx_dlc_i, tx_len_o, d;
   logic [2:0] tx_byte_idx_i = 0;
   logic [15:0] tstamp_i = 0;
   logic [1:0] irq_kind_o;
   logic [7:0] rc [6] = '{8'h80, 8'hc0, 8'h40, 8'h41, 8'h00, 8'h40};
   logic [7:0] re [6] = '{8'h02, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00};
   int mismatches = 0, checked = 0, r, i;
   assign rmt_buf_i = rx_buf_i;
   always #20 clk_i = ~clk_i;
   can_msgbuf_length_control can_msgbuf_length_control_i(.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_store_i, .rx_buf_i, .rx_dlc_i,
      .rx_ide_i, .rx_rtr_i, .rx_r1_i, .rx_r0_i, .done_flags_i, .buf_is_tx_i, .rmt_rx_i,
      .rmt_buf_i, .tx_sent_i, .tx_buf_i, .tx_byte_idx_i, .tx_data_i, .tx_sof_i, .tstamp_i,
      .tx_len_o, .tx_remote_o, .tx_stamp_o, .tx_byte_o, .done_set_o, .answer_req_o,
      .event_buf_o, .irq_req_o, .irq_kind_o, .irq_buf_o);
   can_peer_model can_peer_model_i(.clk_i, .go_i(go), .rgo_i(rgo), .frm_i(frm),
      .rx_store_o(rx_store_i), .rmt_rx_o(rmt_rx_i), .ide_o(rx_ide_i), .rtr_o(rx_rtr_i),
      .r1_o(rx_r1_i), .r0_o(rx_r0_i), .buf_o(rx_buf_i), .dlc_o(rx_dlc_i));
   task chk(input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %0t exp %h got %h", $time, e, g);
      end
   endtask
   task final_report;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // single classic cycle; ack sampled at the edge, then one idle cycle
   task wb(input logic w, input logic [9:0] a, input logic [7:0] dt);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= dt; sel_i <= sl;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      @(posedge clk_i);
   endtask
   task watch;
      o = 0;
      repeat (4) begin
         @(posedge clk_i);
         o |= {3'h0, irq_req_o, irq_kind_o & {2{irq_req_o}}, done_set_o, answer_req_o};
      end
   endtask
   initial begin
      #400000;
      mismatches++;
      final_report;
   end
   initial begin
      r = $urandom(32'hc3f0);
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      for (i = 0; i < 16; i++) begin
         b = $urandom; c = $urandom & 8'hf1; d = $urandom;
         wb(1, {b, 5'h04}, {4'h0, d});
         wb(0, {b, 5'h04}, 0); chk({4'h0, d}, q);
         wb(1, {b, 5'h05}, c);
         wb(0, {b, 5'h05}, 0); chk(c, q);
         wb(0, {b, 5'h00}, 0); chk(8'h00, q);
         if (i == 0) begin
            sl = 0;
            wb(1, {b, 5'h05}, ~c & 8'hf1);
            sl = 1;
            wb(0, {b, 5'h05}, 0);
            chk(c, q);
         end
      end
      for (i = 0; i < 8; i++) begin
         b = $urandom; c = $urandom & 8'hf1; r = $urandom;
         if (i == 0) r[3:2] = 2'b11;
         wb(1, {b, 5'h05}, c);
         done_flags_i[b] <= r[4];
         frm <= {b, r[8:5], r[3:0]};
         go <= 1;
         @(posedge clk_i);
         go <= 0;
         repeat (3) @(posedge clk_i);
         wb(0, {b, 5'h04}, 0); chk({4'h0, r[3] & r[2] ? 4'h0 : r[8:5]}, q);
         wb(0, {b, 5'h05}, 0); chk({c[7:4], r[4], r[1:0], c[0]}, q);
      end
      for (i = 0; i < 6; i++) begin
         b = $urandom;
         buf_is_tx_i <= i < 5 ? '1 : '0;
         wb(1, {b, 5'h05}, rc[i]);
         frm <= {b, 8'h00};
         rgo <= 1;
         @(posedge clk_i);
         rgo <= 0;
         watch; chk(re[i], o);
         chk({3'h0, b}, {3'h0, event_buf_o});
      end
      b = $urandom; r = $urandom;
      buf_is_tx_i <= '1;
      wb(1, {b, 5'h04}, 8'h0b);
      wb(1, {b, 5'h05}, 8'h20);
      tx_buf_i <= b; tstamp_i <= r[15:0]; tx_data_i <= r[23:16]; tx_sof_i <= 1;
      @(posedge clk_i);
      tx_sof_i <= 0;
      for (i = 5; i < 8; i++) begin
         tx_byte_idx_i <= i;
         repeat (2) @(posedge clk_i);
         chk(i == 6 ? r[15:8] : i == 7 ? r[7:0] : r[23:16], tx_byte_o);
      end
      chk(8'h88, {tx_stamp_o, tx_remote_o, 2'h0, tx_len_o});
      for (i = 0; i < 2; i++) begin
         wb(1, {b, 5'h05}, i ? 8'h01 : 8'h10);
         tx_sent_i <= 1;
         @(posedge clk_i);
         tx_sent_i <= 0;
         watch; chk(i ? 8'h00 : 8'h14, o);
         chk({3'h0, b}, {3'h0, irq_buf_o});
         chk(i ? 8'h01 : 8'h00, {7'h0, tx_remote_o});
      end
      final_report;
   end
endmodule
bind can_msgbuf_length_control can_msgbuf_checker can_msgbuf_checker_i(.clk_i, .rst_i,
   .cyc_i, .stb_i, .ack_o, .rx_store_i, .tx_sent_i, .rmt_rx_i, .tx_stamp_o, .done_set_o,
   .answer_req_o, .irq_req_o, .rmt_buf_i, .tx_buf_i, .buf_is_tx_i, .tx_len_o);
